// ===== dv/adc_core_model.sv
// Behavioural analog core standing behind the sequencer control.
// Assumes the sequencer latches the result while busy is still high.
`timescale 1ns/1ns
module adc_core_model
(
  input wire logic clk,
  input wire logic [2:0] channel,
  input wire logic active,
  output logic [9:0] result
);
  // =====================================================
  // Channel-coded result while busy; flips every cycle otherwise
  // so that a late or early latch shows up as wrong data
  initial result = 10'h155;
  always @(posedge clk)
  begin
    result <= active ? {channel, 7'h2B} : ~result;
  end
endmodule // adc_core_model

// ===== dv/adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer control.
// Assumes an AXI4-Lite master here and the core model on the far side.
`timescale 1ns/1ns
module adc_sequencer_control_tb;
  logic clk = 0, arst_n = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic tmr = 0, ext_n = 1, sprev = 0, ce = 1;
  logic [9:0] awaddr = 0, araddr = 0, core;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic [2:0] c;
  wire logic awr, wrdy, bv, arr, rv, samp, act, aios, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] chan;
  int bad_count = 0, n_checks = 0, scnt = 0;
  logic [2:0] chq[$];
  logic [33:0] rq[$], mq[$];
  adc_sequencer_control dut (.CLOCK(clk), .ARST_N(arst_n), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .TIMER1_OUT(tmr), .EXT_TRIG_N(ext_n), .CORE_RESULT(core), .CHANNEL(chan),
    .SAMPLE(samp), .CONV_ACTIVE(act), .AUTO_IO_SERVICE_REQ(aios), .IRQ(irq));
  adc_core_model core_i (.clk(clk), .channel(chan), .active(act), .result(core));
  // =====================================================
  // Clock, 8 ns period
  initial forever #4 clk = ~clk;
  // Watchdog sized well above the longest expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  // =====================================================
  // Comparison and verdict
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // =====================================================
  // Bus tasks; readiness sampled at the falling edge, so it is settled
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do
    begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      @(posedge clk);
      if (ta)
        awv <= 0;
      if (tw)
        wv <= 0;
      n++;
    end
    while (!tb && n < 200);
    bready <= 0;
    chk("bresp", tb ? bresp : 2'h3, adc_seq_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [9:0] a, input logic [33:0] e, input logic [33:0] m);
    int n;
    logic ta, tr;
    n = 0;
    @(posedge clk);
    rq.push_back(e);
    mq.push_back(m);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do
    begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      @(posedge clk);
      if (ta)
        arv <= 0;
      n++;
    end
    while (!tr && n < 200);
    rready <= 0;
    if (!tr)
      bad_count++;
  endtask
  // Wait for all noted conversions to start, then idle so strays are caught
  task automatic drain();
    int n;
    n = 0;
    while (chq.size() > 0 && n < 9000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 9000)
      bad_count++;
    repeat (1000) @(posedge clk);
  endtask
  // =====================================================
  // Output watcher: read data and each conversion start take the oldest note
  always @(negedge clk)
  begin
    if (rv && rready && rq.size() > 0)
      chk("read", {rresp, rdata} & mq.pop_front(), rq.pop_front());
    if (samp && !sprev)
      chk("channel", chan, chq.size() > 0 ? chq.pop_front() : 3'bx);
    if (!samp && sprev)
      chk("sample_len", scnt, adc_seq_pkg::SAMPLE_MIN_CYC);
    scnt = samp ? scnt + 1 : 0;
    sprev = samp;
  end
  // =====================================================
  // Main sequence
  initial
  begin
    void'($urandom(15));
    repeat (12) @(posedge clk);
    arst_n <= 1;
    rd(adc_seq_pkg::MODE_CHAN_ADDR, 0, 34'h3_0000_00FF);
    rd(adc_seq_pkg::CTRL_STAT_ADDR, 0, 34'h3_0000_00FF);
    rd(10'h3F0, {adc_seq_pkg::RESP_SLVERR, 32'h0}, '1);
    // Single pass over a wrapping range, event raised through the mask
    wr(adc_seq_pkg::IRQ_MASK_ADDR, 32'h100, 4'h2);
    wr(adc_seq_pkg::MODE_CHAN_ADDR, 32'h39, 4'h1);
    chq = '{3'd7, 3'd0, 3'd1};
    wr(adc_seq_pkg::CTRL_STAT_ADDR, 32'h02, 4'h1);
    drain();
    chk("irq_masked", irq, 1);
    rd(adc_seq_pkg::RESULT_ADDR, 34'h0AB, 34'h3_0000_83FF);
    rd(adc_seq_pkg::IRQ_MASK_ADDR, 34'h101, 34'h3_0000_0301);
    @(negedge clk);
    chk("irq_cleared", irq, 0);
    wr(adc_seq_pkg::IRQ_MASK_ADDR, 32'h0, 4'h2);
    // Timer rising edge, then external falling edge, on a random channel
    c = 3'($urandom_range(7, 0));
    wr(adc_seq_pkg::MODE_CHAN_ADDR, {24'h0, 2'b01, c, c}, 4'h1);
    wr(adc_seq_pkg::CTRL_STAT_ADDR, 32'h08, 4'h1);
    chq.push_back(c);
    // Edge arrives while frozen; it must be held back until enable returns
    ce <= 0;
    tmr <= 1;
    repeat (20) @(negedge clk);
    chk("frozen_busy", act, 0);
    @(posedge clk);
    ce <= 1;
    drain();
    tmr <= 0;
    wr(adc_seq_pkg::CTRL_STAT_ADDR, 32'h0C, 4'h1);
    chq.push_back(c);
    ext_n <= 0;
    drain();
    ext_n <= 1;
    // Step mode: one channel per start
    wr(adc_seq_pkg::MODE_CHAN_ADDR, 32'hE5, 4'h1);
    for (int i = 4; i < 6; i++)
    begin
      chq.push_back(3'(i));
      wr(adc_seq_pkg::CTRL_STAT_ADDR, 32'h06, 4'h1);
      drain();
    end
    // Step mode stays armed, so reset before switching to repeat mode
    arst_n <= 0;
    repeat (12) @(posedge clk);
    arst_n <= 1;
    // Repeat mode with interrupts: held off until the result is read
    wr(adc_seq_pkg::MODE_CHAN_ADDR, 32'h93, 4'h1);
    chq.push_back(3'd2);
    wr(adc_seq_pkg::CTRL_STAT_ADDR, 32'h22, 4'h1);
    drain();
    chk("irq_end", irq, 1);
    chk("auto_io", aios, 1);
    rd(adc_seq_pkg::CTRL_STAT_ADDR, 34'hF0, 34'h3_0000_00FF);
    rd(adc_seq_pkg::IRQ_MASK_ADDR, 34'h003, 34'h3_0000_0303);
    chq.push_back(3'd3);
    rd(adc_seq_pkg::RESULT_ADDR, 34'h12B, 34'h3_0000_83FF);
    drain();
    wr(adc_seq_pkg::RESULT_ADDR, 32'h8000, 4'h2);
    chq.push_back(3'd2);
    rd(adc_seq_pkg::RESULT_ADDR, 34'h806A, 34'h3_0000_83FF);
    drain();
    // Second reset in mid-run stops the scan
    arst_n <= 0;
    repeat (12) @(posedge clk);
    arst_n <= 1;
    rd(adc_seq_pkg::CTRL_STAT_ADDR, 0, 34'h3_0000_00FF);
    wr(adc_seq_pkg::RESULT_ADDR, 32'h8000, 4'h2);
    rd(adc_seq_pkg::RESULT_ADDR, 34'h8000, 34'h3_0000_8000);
    finish_test();
  end
endmodule // adc_sequencer_control_tb

// ===== rtl/adc_conv_timer.sv
// Per-channel conversion timer: sample phase, then approximation phase.
// Assumes the sequencer latches the core result when done pulses.
`timescale 1ns/1ns
module adc_conv_timer
#(
  parameter int SAMPLE_CYC = adc_seq_pkg::SAMPLE_MIN_CYC,
  parameter int APPROX_CYC = adc_seq_pkg::APPROX_MIN_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic go,
  output logic sampling,
  output logic active,
  output logic done
);
  typedef enum logic [1:0] {T_IDLE, T_SAMPLE, T_APPROX} tstate_t;
  tstate_t state_reg;
  tstate_t state_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;

  // =====================================================================
  // Phase sequencing
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done = 1'b0;
    if (ce)
    begin
      unique case (state_reg)
        T_IDLE:
        begin
          if (go)
          begin
            state_next = T_SAMPLE;
            cnt_next = 12'(SAMPLE_CYC - 1);
          end
        end
        T_SAMPLE:
        begin
          if (cnt_reg == 12'h000)
          begin
            state_next = T_APPROX;
            cnt_next = 12'(APPROX_CYC - 1);
          end
          else
            cnt_next = cnt_reg - 12'h001;
        end
        T_APPROX:
        begin
          if (cnt_reg == 12'h000)
          begin
            state_next = T_IDLE;
            done = 1'b1;
          end
          else
            cnt_next = cnt_reg - 12'h001;
        end
        default: state_next = T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= T_IDLE;
      cnt_reg <= 12'h000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign sampling = (state_reg == T_SAMPLE);
  assign active = (state_reg != T_IDLE);

  // Conversion time check
  int unsigned len_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      len_q <= 0;
    else if (ce)
      len_q <= (state_reg == T_IDLE) ? 0 : len_q + 1;
  end
  a_conv_min_len: assert property (@(posedge clk) disable iff (!arst_n)
    done |-> len_q + 1 >= adc_seq_pkg::CONV_MIN_CYC)
    else $error("conversion shorter than minimum");
  a_sample_min_len: assert property (@(posedge clk) disable iff (!arst_n)
    (ce && state_reg == T_SAMPLE && state_next == T_APPROX) |-> len_q + 1 >= SAMPLE_CYC)
    else $error("sampling shorter than minimum");

  // =====================================================================
  // Phase order: a taken start opens an unbroken sampling stretch
  sequence s_go_taken;
    ce && state_reg == T_IDLE && go;
  endsequence
  sequence s_sampling_run;
    sampling [*8];
  endsequence
  a_sample_first: assert property (@(posedge clk) disable iff (!arst_n)
    s_go_taken |=> s_sampling_run)
    else $error("sampling not entered after start");
endmodule // adc_conv_timer

// ===== rtl/adc_seq_pkg.sv
// Constants and types shared by the converter sequencer control files.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register port.
// =====================================================================
// Functional notes
// - Software selects ten-bit or eight-bit result for each conversion.
// - Software chooses which of eight analog channels are converted.
// - Single-pass mode converts one channel or a range once, then halts.
// - Repeating mode restarts the channel range after each pass by itself.
// - Paused-step mode converts one channel per start event, then waits.
// - Conversion end raises interrupt request and auto I/O service request.
// - With interrupts enabled, unread results are held between single and repeating scan steps; a paused-step or idle start overwrites them.
// - Start source is software, timer rising edge, or external falling edge.
// - Whole conversion including sampling lasts at least 6.13 us.
// - Sampling lasts at least 3.75 us before approximation begins.
package adc_seq_pkg;
  // =====================================================================
  // Register map; printed offsets are word indices, byte address is 4x
  localparam logic [7:0] MODE_CHAN_IDX = 8'h2C;
  localparam logic [7:0] CTRL_STAT_IDX = 8'h2D;
  localparam logic [7:0] RESULT_IDX = 8'h2E;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h30;
  localparam logic [9:0] MODE_CHAN_ADDR = {MODE_CHAN_IDX, 2'b00};
  localparam logic [9:0] CTRL_STAT_ADDR = {CTRL_STAT_IDX, 2'b00};
  localparam logic [9:0] RESULT_ADDR = {RESULT_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  localparam logic [7:0] MODE_CHAN_RESET = 8'h00;
  localparam logic [7:0] CTRL_STAT_RESET = 8'h00;
  // =====================================================================
  // Field positions, control/status register
  localparam int BUSY_BIT = 7;
  localparam int DONE_BIT = 6;
  localparam int IRQ_EN_BIT = 5;
  localparam int HOLDOFF_BIT = 4;
  localparam int SRC_HI_BIT = 3;
  localparam int SRC_LO_BIT = 2;
  localparam int GO_BIT = 1;
  // Mode/channel register and result register fields
  localparam int PATTERN_HI_BIT = 7;
  localparam int PATTERN_LO_BIT = 6;
  localparam int FIRST_HI_BIT = 5;
  localparam int FIRST_LO_BIT = 3;
  localparam int LAST_HI_BIT = 2;
  localparam int LAST_LO_BIT = 0;
  localparam int RES_SEL_BIT = 15;
  // Interrupt status/mask bits
  localparam int EV_DONE_BIT = 0;
  localparam int EV_HOLD_BIT = 1;
  localparam int EV_WIDTH = 2;
  // =====================================================================
  // Timing: figures in ns, cycle counts derived from 8 ns clock
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int CONV_MIN_NS = 6130;
  localparam int SAMPLE_MIN_NS = 3750;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int APPROX_MIN_CYC = CONV_MIN_CYC - SAMPLE_MIN_CYC;
  localparam int RESULT_BITS = 10;
  // =====================================================================
  // Modes and start sources
  typedef enum logic [1:0] {PAT_SINGLE, PAT_SINGLE2, PAT_REPEAT, PAT_STEP} pattern_t;
  typedef enum logic [1:0] {SRC_SOFT, SRC_SOFT2, SRC_TIMER, SRC_EXT} source_t;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== rtl/adc_sequencer_control.sv
// Converter sequencer control: modes, channel scan, start, interrupts, AXI4-Lite.
// Assumes an analog core that samples CHANNEL and delivers CORE_RESULT at end.
`timescale 1ns/1ns
module adc_sequencer_control
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic [9:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [9:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TIMER1_OUT,
  input wire logic EXT_TRIG_N,
  input wire logic [9:0] CORE_RESULT,
  output logic [2:0] CHANNEL,
  output logic SAMPLE,
  output logic CONV_ACTIVE,
  output logic AUTO_IO_SERVICE_REQ,
  output logic IRQ
);
  // =====================================================================
  // Register state
  logic [7:0] mode_chan_reg, mode_chan_next;
  logic irq_en_reg, irq_en_next;
  logic [1:0] src_reg, src_next;
  logic done_reg, done_next;
  logic res_sel_reg, res_sel_next;
  logic [9:0] result_reg, result_next;
  logic unread_reg, unread_next;
  logic [adc_seq_pkg::EV_WIDTH-1:0] ev_reg, ev_next;
  logic [adc_seq_pkg::EV_WIDTH-1:0] mask_reg, mask_next;
  logic [2:0] chan_reg, chan_next;
  logic busy_reg, busy_next;
  logic waiting_reg, waiting_next;
  logic soft_go, start_pulse, conv_go, conv_done, sampling, active, holdoff;
  // Bus state
  logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [9:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic wr_fire, rd_fire;

  wire adc_seq_pkg::pattern_t pattern =
    adc_seq_pkg::pattern_t'(mode_chan_reg[adc_seq_pkg::PATTERN_HI_BIT:adc_seq_pkg::PATTERN_LO_BIT]);
  wire [2:0] first_ch = mode_chan_reg[adc_seq_pkg::FIRST_HI_BIT:adc_seq_pkg::FIRST_LO_BIT];
  wire [2:0] last_ch = mode_chan_reg[adc_seq_pkg::LAST_HI_BIT:adc_seq_pkg::LAST_LO_BIT];

  // Register offset decode, used by both write and read paths
  function automatic logic [2:0] reg_sel(input logic [9:0] addr);
    unique case (addr)
      adc_seq_pkg::MODE_CHAN_ADDR: return 3'h1;
      adc_seq_pkg::CTRL_STAT_ADDR: return 3'h2;
      adc_seq_pkg::RESULT_ADDR: return 3'h3;
      adc_seq_pkg::IRQ_MASK_ADDR: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  // =====================================================================
  // Submodules
  adc_trigger_select u_trig (
    .clk(CLOCK), .arst_n(ARST_N), .ce(CE), .source_sel(src_reg), .soft_go(soft_go),
    .timer_out(TIMER1_OUT), .ext_trig_n(EXT_TRIG_N), .start_pulse(start_pulse));
  adc_conv_timer u_timer (
    .clk(CLOCK), .arst_n(ARST_N), .ce(CE), .go(conv_go), .sampling(sampling),
    .active(active), .done(conv_done));

  // =====================================================================
  // AXI4-Lite handshake; address and data taken in either order
  assign S_AXI_AWREADY = ~aw_reg & ~bv_reg;
  assign S_AXI_WREADY = ~w_reg & ~bv_reg;
  assign S_AXI_ARREADY = ~rv_reg;
  assign wr_fire = aw_reg & w_reg & ~bv_reg & CE;
  assign rd_fire = S_AXI_ARVALID & ~rv_reg & CE;

  always_comb
  begin
    aw_next = aw_reg;
    w_next = w_reg;
    bv_next = bv_reg;
    rv_next = rv_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (CE)
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_next = 1'b1;
        awaddr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_next = 1'b1;
        wdata_next = S_AXI_WDATA;
        wstrb_next = S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_next = 1'b0;
        w_next = 1'b0;
        bv_next = 1'b1;
        bresp_next = (reg_sel(awaddr_reg) == 3'h0) ? adc_seq_pkg::RESP_SLVERR
                                                   : adc_seq_pkg::RESP_OKAY;
      end
      if (bv_reg && S_AXI_BREADY)
        bv_next = 1'b0;
      if (rv_reg && S_AXI_RREADY)
        rv_next = 1'b0;
      if (rd_fire)
      begin
        rv_next = 1'b1;
        rresp_next = adc_seq_pkg::RESP_OKAY;
        unique case (reg_sel(S_AXI_ARADDR))
          3'h1: rdata_next = {24'h000000, mode_chan_reg};
          3'h2: rdata_next = {24'h000000, busy_reg, done_reg, irq_en_reg, holdoff,
                              src_reg, 2'b00};
          3'h3: rdata_next = {16'h0000, res_sel_reg, 5'h00,
                              res_sel_reg ? {2'b00, result_reg[9:2]} : result_reg};
          3'h4: rdata_next = {16'h0000, 6'h00, mask_reg, 6'h00, ev_reg};
          default:
          begin
            rdata_next = 32'h00000000;
            rresp_next = adc_seq_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      bv_reg <= 1'b0;
      rv_reg <= 1'b0;
      awaddr_reg <= 10'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bresp_reg <= 2'h0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      bv_reg <= bv_next;
      rv_reg <= rv_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign S_AXI_BVALID = bv_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rv_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // =====================================================================
  // Sequencer and registers
  wire wr_mode = wr_fire && reg_sel(awaddr_reg) == 3'h1 && wstrb_reg[0];
  wire wr_ctrl = wr_fire && reg_sel(awaddr_reg) == 3'h2 && wstrb_reg[0];
  wire wr_res = wr_fire && reg_sel(awaddr_reg) == 3'h3 && wstrb_reg[1];
  wire wr_mask = wr_fire && reg_sel(awaddr_reg) == 3'h4 && wstrb_reg[1];
  wire rd_res = rd_fire && reg_sel(S_AXI_ARADDR) == 3'h3;
  wire rd_ev = rd_fire && reg_sel(S_AXI_ARADDR) == 3'h4;
  assign soft_go = wr_ctrl & wdata_reg[adc_seq_pkg::GO_BIT];
  // hold off while waiting after a conversion, an unread result exists and interrupts are on
  assign holdoff = irq_en_reg & unread_reg & waiting_reg;
  assign conv_go = CE & busy_reg & ~active & ~waiting_reg & ~holdoff;

  always_comb
  begin
    mode_chan_next = mode_chan_reg;
    irq_en_next = irq_en_reg;
    src_next = src_reg;
    done_next = done_reg;
    res_sel_next = res_sel_reg;
    result_next = result_reg;
    unread_next = unread_reg;
    ev_next = ev_reg;
    mask_next = mask_reg;
    chan_next = chan_reg;
    busy_next = busy_reg;
    waiting_next = waiting_reg;
    if (CE)
    begin
      if (wr_mode)
        mode_chan_next = wdata_reg[7:0];
      if (wr_res)
        res_sel_next = wdata_reg[adc_seq_pkg::RES_SEL_BIT];
      if (wr_mask)
        mask_next = wdata_reg[8 +: adc_seq_pkg::EV_WIDTH];
      if (wr_ctrl)
      begin
        irq_en_next = wdata_reg[adc_seq_pkg::IRQ_EN_BIT];
        src_next = wdata_reg[adc_seq_pkg::SRC_HI_BIT:adc_seq_pkg::SRC_LO_BIT];
        if (!wdata_reg[adc_seq_pkg::DONE_BIT])
          done_next = 1'b0;
      end
      if (rd_res)
        unread_next = 1'b0;
      if (rd_ev)
        ev_next = '0;
      if (start_pulse)
      begin
        if (!busy_reg)
        begin
          busy_next = 1'b1;
          chan_next = first_ch;
          waiting_next = 1'b0;
        end
        else if (waiting_reg && pattern == adc_seq_pkg::PAT_STEP)
          waiting_next = 1'b0;
      end
      else if (waiting_reg && !holdoff && pattern != adc_seq_pkg::PAT_STEP)
        waiting_next = 1'b0;
      if (holdoff)
        ev_next[adc_seq_pkg::EV_HOLD_BIT] = 1'b1;
      if (conv_done)
      begin
        result_next = CORE_RESULT;
        unread_next = 1'b1;
        // end flag, set wins over clear
        done_next = 1'b1;
        ev_next[adc_seq_pkg::EV_DONE_BIT] = 1'b1;
        chan_next = (chan_reg == last_ch) ? first_ch : chan_reg + 3'h1;
        waiting_next = 1'b1;
        unique case (pattern)
          adc_seq_pkg::PAT_REPEAT: busy_next = 1'b1;
          adc_seq_pkg::PAT_STEP: busy_next = 1'b1;
          default: busy_next = (chan_reg != last_ch);
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      mode_chan_reg <= adc_seq_pkg::MODE_CHAN_RESET;
      irq_en_reg <= 1'b0;
      src_reg <= 2'b00;
      done_reg <= 1'b0;
      res_sel_reg <= 1'b0;
      result_reg <= 10'h000;
      unread_reg <= 1'b0;
      ev_reg <= '0;
      mask_reg <= '0;
      chan_reg <= 3'h0;
      busy_reg <= 1'b0;
      waiting_reg <= 1'b0;
    end
    else
    begin
      mode_chan_reg <= mode_chan_next;
      irq_en_reg <= irq_en_next;
      src_reg <= src_next;
      done_reg <= done_next;
      res_sel_reg <= res_sel_next;
      result_reg <= result_next;
      unread_reg <= unread_next;
      ev_reg <= ev_next;
      mask_reg <= mask_next;
      chan_reg <= chan_next;
      busy_reg <= busy_next;
      waiting_reg <= waiting_next;
    end
  end

  // Outputs; interrupt from done flag with its enable, or from any masked event
  assign CHANNEL = chan_reg;
  assign SAMPLE = sampling;
  assign CONV_ACTIVE = busy_reg;
  assign AUTO_IO_SERVICE_REQ = done_reg & irq_en_reg;
  assign IRQ = (done_reg & irq_en_reg) | |(ev_reg & mask_reg);

  // =====================================================================
  // Checks
  a_no_overwrite: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (irq_en_reg && unread_reg && !rd_res) |-> !conv_go)
    else $error("conversion started over unread result");
  a_single_halts: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (conv_done && pattern == adc_seq_pkg::PAT_SINGLE && chan_reg == last_ch && !start_pulse)
    |=> !busy_reg)
    else $error("single pass did not halt");
  a_repeat_wraps: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (conv_done && pattern == adc_seq_pkg::PAT_REPEAT && chan_reg == last_ch)
    |=> busy_reg && chan_reg == first_ch)
    else $error("repeat did not wrap");
  a_step_waits: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (conv_done && pattern == adc_seq_pkg::PAT_STEP) |=> waiting_reg)
    else $error("step mode did not wait");
  a_done_irq: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (conv_done && irq_en_reg && !wr_ctrl) |=> IRQ && AUTO_IO_SERVICE_REQ)
    else $error("no request at conversion end");
  a_start_busy: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (start_pulse && !busy_reg) |=> busy_reg && chan_reg == $past(first_ch))
    else $error("start not taken");
endmodule // adc_sequencer_control

// ===== rtl/adc_trigger_select.sv
// Start event selector: software, timer rising edge, external falling edge.
// Assumes trigger inputs are synchronous to CLOCK.
`timescale 1ns/1ns
module adc_trigger_select
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [1:0] source_sel,
  input wire logic soft_go,
  input wire logic timer_out,
  input wire logic ext_trig_n,
  output logic start_pulse
);
  logic timer_reg;
  logic timer_next;
  logic ext_reg;
  logic ext_next;

  // =====================================================================
  // Edge history
  always_comb
  begin
    timer_next = timer_in_hold(ce, timer_out, timer_reg);
    ext_next = timer_in_hold(ce, ext_trig_n, ext_reg);
  end

  function automatic logic timer_in_hold(input logic en, input logic d, input logic q);
    return en ? d : q;
  endfunction

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timer_reg <= 1'b0;
      ext_reg <= 1'b1;
    end
    else
    begin
      timer_reg <= timer_next;
      ext_reg <= ext_next;
    end
  end

  // source select
  // Software start always accepted as well, so a stuck edge can be bypassed
  always_comb
  begin
    unique case (adc_seq_pkg::source_t'(source_sel))
      adc_seq_pkg::SRC_TIMER: start_pulse = ce & (soft_go | (timer_out & ~timer_reg));
      adc_seq_pkg::SRC_EXT: start_pulse = ce & (soft_go | (~ext_trig_n & ext_reg));
      default: start_pulse = ce & soft_go;
    endcase
  end
endmodule // adc_trigger_select
